// *** hw/ulpi_port_cfg.svh ***
// Purpose: Shared constants for the eight-bit transceiver port and its link end.
// Assumes: One 125 MHz clock, synchronous active-low reset on each end.
// Notes:   Timing counts are in system clock cycles.
`ifndef ULPI_PORT_CFG_SVH
`define ULPI_PORT_CFG_SVH

// ----------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------
`define DATA_W          8
`define CLK_PERIOD_NS   8
`define RST_MIN_NS      1000
// Least reset hold, rounded up to whole cycles
`define RST_MIN_CYC     ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W       8
// Interface clock divider: toggle every N cycles
`define IFCLK_HALF_CYC  1
`define RST_VAL_BYTE    8'h00

`endif

// *** hw/ulpi_port_pkg.sv ***
// Purpose: Types shared by both ends of the port.
// Assumes: Constants come from ulpi_port_cfg.svh.
// Notes:   State codes are one-hot.
`include "ulpi_port_cfg.svh"
package ulpi_port_pkg;
  // Device end states
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,   // Bus released, watching for commands
    DEV_RX   = 3'b010,   // Receiving link bytes
    DEV_TX   = 3'b100    // Owning bus, sending to link
  } dev_state_t;
  // Link end states
  typedef enum logic [2:0] {
    LNK_IDLE = 3'b001,   // Not sending
    LNK_SEND = 3'b010,   // Presenting bytes
    LNK_STOP = 3'b100    // Stop pulse cycle
  } lnk_state_t;
  typedef logic [`DATA_W-1:0] byte_t;
endpackage

// *** hw/ulpi_port_if.sv ***
// Purpose: Shared pin bundle between transceiver end and link end.
// Assumes: Testbench resolves the data wire from the two enables.
// Notes:   No clocking block.
`include "ulpi_port_cfg.svh"
interface ulpi_port_if;
  import ulpi_port_pkg::*;
  byte_t dev_data_o;               // Data driven by device
  logic  dev_data_oe;              // Device drives data
  byte_t lnk_data_o;               // Data driven by link
  logic  lnk_data_oe;              // Link drives data
  byte_t data_i;                   // Resolved bus level
  logic  dir;                      // Bus owner, high for device
  logic  dir_oe;                   // Device drives dir
  logic  nxt;                      // Throttle from device
  logic  nxt_oe;                   // Device drives nxt
  logic  stp;                      // Stop from link
  logic  chip_reset_n_pin;         // Chip reset from link side
  logic  interface_clock_output;   // Interface clock from device
  logic  clk_strap;                // Clock pin strapped high
  modport device (
    output dev_data_o, dev_data_oe, dir, dir_oe, nxt, nxt_oe, interface_clock_output,
    input  data_i, stp, chip_reset_n_pin, clk_strap
  );
  modport link (
    output lnk_data_o, lnk_data_oe, stp, chip_reset_n_pin,
    input  data_i, dir, nxt
  );
endinterface // ulpi_port_if

// *** hw/ulpi_phy_port.sv ***
// Purpose: Transceiver end of the port: direction, throttle, stop, reset.
// Assumes: Link keeps its own stepping and stop pulse; one clock.
// Notes:   Reset pin sampled through two flops before use.
`include "ulpi_port_cfg.svh"
module ulpi_phy_port
  import ulpi_port_pkg::*;
(
  input  wire logic  CLOCK,          // System clock
  input  wire logic  NRST,           // Synchronous reset, active low
  ulpi_port_if.device PORT,          // Link-facing pins
  input  wire byte_t TX_BYTE,        // Byte to send to link
  input  wire logic  TX_VALID,       // Byte waiting
  input  wire logic  TX_LAST,        // Final byte of packet
  input  wire logic  RX_READY,       // User can take a byte
  output logic       TX_TAKEN,       // Byte sent this cycle
  output byte_t      RX_BYTE,        // Byte received from link
  output logic       RX_STROBE,      // RX_BYTE valid
  output logic       RX_END,         // Previous byte was the last
  output logic       CLOCK_IN_MODE,  // Clock-in mode selected
  output logic       ACTIVE          // Port out of reset
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic       rst_s1_q;      // First stage
  logic       rst_s2_q;      // Second stage
  logic       run_q;         // Port running
  logic [`RST_CNT_W-1:0] low_cnt_q;   // Cycles reset seen low
  logic       armed_q;       // Low long enough to clear state
  dev_state_t st_q;          // Port state
  logic       turn_q;        // Bus turning round after dir fall

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= PORT.chip_reset_n_pin;
      rst_s2_q <= rst_s1_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      low_cnt_q <= '0;
      armed_q   <= 1'b1;
    end else if (!rst_s2_q) begin
      if (low_cnt_q != `RST_CNT_W'(`RST_MIN_CYC))
        low_cnt_q <= low_cnt_q + 1'b1;
      else
        armed_q <= 1'b1;
    end else begin
      low_cnt_q <= '0;
      armed_q   <= 1'b0;
    end
  end

  // Resume one cycle after synced release
  always_ff @(posedge CLOCK) begin
    if (!NRST)
      run_q <= 1'b0;
    else
      run_q <= rst_s2_q;
  end

  // Sample clock mode strap while synced chip reset is low; hold it after release
  always_ff @(posedge CLOCK) begin
    if (!NRST)
      CLOCK_IN_MODE <= 1'b0;
    else if (!rst_s2_q)
      CLOCK_IN_MODE <= PORT.clk_strap;
  end

  // ----------------------------------------------------------------
  // Interface clock output
  // ----------------------------------------------------------------
  logic ifclk_q;  // Divided clock
  // Drive clock out only in clock-out mode
  always_ff @(posedge CLOCK) begin
    if (!NRST || !run_q || CLOCK_IN_MODE)
      ifclk_q <= 1'b0;
    else
      ifclk_q <= ~ifclk_q;
  end
  assign PORT.interface_clock_output = ifclk_q;

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  // Ownership follows send data
  always_ff @(posedge CLOCK) begin
    if (!NRST || !run_q) begin
      st_q <= DEV_IDLE;
    end else begin
      unique case (st_q)
        DEV_IDLE: begin
          // Link command byte has non-zero value
          if (TX_VALID)
            st_q <= DEV_TX;
          else if (!turn_q && PORT.data_i != `RST_VAL_BYTE)
            st_q <= DEV_RX;
        end
        DEV_RX: begin
          if (PORT.stp)
            st_q <= DEV_IDLE;
        end
        DEV_TX: begin
          if (TX_VALID && TX_LAST)
            st_q <= DEV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, registered
  // ----------------------------------------------------------------
  logic  dir_q;      // Direction
  logic  nxt_q;      // Throttle
  logic  oe_q;       // Control outputs enabled
  byte_t dout_q;     // Data out
  logic  doe_q;      // Data enable
  byte_t last_q;     // Byte seen last cycle

  always_ff @(posedge CLOCK) begin
    if (!NRST || !run_q) begin
      dir_q  <= 1'b0;
      nxt_q  <= 1'b0;
      oe_q   <= 1'b0;
      dout_q <= `RST_VAL_BYTE;
      doe_q  <= 1'b0;
    end else begin
      oe_q  <= 1'b1;
      dir_q <= (st_q == DEV_TX) || (st_q == DEV_IDLE && TX_VALID);
      nxt_q <= (st_q != DEV_TX) && !PORT.stp && RX_READY &&
               (st_q == DEV_RX || (!turn_q && PORT.data_i != `RST_VAL_BYTE)) && !TX_VALID;
      dout_q <= TX_BYTE;
      // Last byte still stands while dir is high
      doe_q  <= (st_q == DEV_TX);
    end
  end

  // Ignore the undriven turnaround cycle after dir falls
  always_ff @(posedge CLOCK) begin
    if (!NRST || !run_q)
      turn_q <= 1'b0;
    else
      turn_q <= dir_q;
  end
  assign PORT.dir         = dir_q;
  assign PORT.dir_oe      = oe_q;
  assign PORT.nxt         = nxt_q;
  assign PORT.nxt_oe      = oe_q;
  assign PORT.dev_data_o  = dout_q;
  assign PORT.dev_data_oe = doe_q;

  // ----------------------------------------------------------------
  // User side outputs
  // ----------------------------------------------------------------
  // Byte accepted under nxt; stop marks end
  always_ff @(posedge CLOCK) begin
    if (!NRST || !run_q) begin
      RX_BYTE   <= `RST_VAL_BYTE;
      RX_STROBE <= 1'b0;
      RX_END    <= 1'b0;
      TX_TAKEN  <= 1'b0;
      last_q    <= `RST_VAL_BYTE;
    end else begin
      last_q    <= PORT.data_i;
      RX_STROBE <= nxt_q && !PORT.stp;
      RX_BYTE   <= PORT.data_i;
      RX_END    <= PORT.stp && (st_q == DEV_RX);
      TX_TAKEN  <= (st_q == DEV_TX) && TX_VALID;
    end
  end

  // Activity flag
  always_ff @(posedge CLOCK) begin
    if (!NRST)
      ACTIVE <= 1'b0;
    else
      ACTIVE <= run_q && !armed_q;
  end
endmodule // ulpi_phy_port

// *** hw/ulpi_link_end.sv ***
// Purpose: Link end: steps bytes on nxt, pulses stop, drives chip reset.
// Assumes: Device raises nxt when it takes the presented byte.
// Notes:   Reset pin held low the least time after system reset.
`include "ulpi_port_cfg.svh"
module ulpi_link_end
  import ulpi_port_pkg::*;
(
  input  wire logic  CLOCK,      // System clock
  input  wire logic  NRST,       // Synchronous reset, active low
  ulpi_port_if.link  PORT,       // Device-facing pins
  input  wire byte_t SEND_BYTE,  // Byte to send
  input  wire logic  SEND_VALID, // Byte waiting
  input  wire logic  SEND_LAST,  // Final byte
  output logic       SEND_TAKEN, // Byte stepped past
  output byte_t      RECV_BYTE,  // Byte from device
  output logic       RECV_VALID, // RECV_BYTE valid
  output logic       READY       // Device released from reset
);
  lnk_state_t st_q;                       // Sender state
  logic [`RST_CNT_W-1:0] rcnt_q;          // Reset hold counter
  logic       rstn_q;                     // Chip reset pin
  byte_t      dout_q;                     // Presented byte
  logic       doe_q;                      // Data enable
  logic       stp_q;                      // Stop pulse
  logic       last_q;                     // Presented byte is last

  // ----------------------------------------------------------------
  // Chip reset generation
  // ----------------------------------------------------------------
  // Hold chip reset low at least 1 us
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rcnt_q <= '0;
      rstn_q <= 1'b0;
    end else if (rcnt_q != `RST_CNT_W'(`RST_MIN_CYC)) begin
      rcnt_q <= rcnt_q + 1'b1;
    end else begin
      rstn_q <= 1'b1;
    end
  end
  assign PORT.chip_reset_n_pin = rstn_q;

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  // Step on nxt, single stop pulse
  always_ff @(posedge CLOCK) begin
    if (!NRST || !rstn_q) begin
      st_q   <= LNK_IDLE;
      dout_q <= `RST_VAL_BYTE;
      doe_q  <= 1'b0;
      stp_q  <= 1'b0;
      last_q <= 1'b0;
    end else begin
      unique case (st_q)
        LNK_IDLE: begin
          stp_q  <= 1'b0;
          // Own the bus whenever dir is low; idle byte means no command
          doe_q  <= !PORT.dir;
          dout_q <= `RST_VAL_BYTE;
          if (SEND_VALID && !PORT.dir) begin
            dout_q <= SEND_BYTE;
            last_q <= SEND_LAST;
            doe_q  <= 1'b1;
            st_q   <= LNK_SEND;
          end
        end
        LNK_SEND: begin
          if (PORT.dir) begin
            // Device took the bus: abandon
            doe_q  <= 1'b0;
            dout_q <= `RST_VAL_BYTE;
            st_q   <= LNK_IDLE;
          end else if (PORT.nxt && last_q) begin
            dout_q <= `RST_VAL_BYTE;
            stp_q  <= 1'b1;
            st_q   <= LNK_STOP;
          end else if (PORT.nxt) begin
            dout_q <= SEND_BYTE;
            last_q <= SEND_LAST;
          end
        end
        LNK_STOP: begin
          // Keep driving the idle byte so the device sees no command
          stp_q  <= 1'b0;
          doe_q  <= !PORT.dir;
          dout_q <= `RST_VAL_BYTE;
          st_q   <= LNK_IDLE;
        end
      endcase
    end
  end
  assign PORT.lnk_data_o  = dout_q;
  assign PORT.lnk_data_oe = doe_q;
  assign PORT.stp         = stp_q;

  // ----------------------------------------------------------------
  // User outputs
  // ----------------------------------------------------------------
  // Report steps and bytes from device
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      SEND_TAKEN <= 1'b0;
      RECV_BYTE  <= `RST_VAL_BYTE;
      RECV_VALID <= 1'b0;
      READY      <= 1'b0;
    end else begin
      SEND_TAKEN <= (st_q == LNK_IDLE && SEND_VALID && !PORT.dir && rstn_q) ||
                    (st_q == LNK_SEND && PORT.nxt && !last_q && !PORT.dir);
      RECV_BYTE  <= PORT.data_i;
      RECV_VALID <= PORT.dir;
      READY      <= rstn_q;
    end
  end
endmodule // ulpi_link_end

// *** dv/ulpi_port_properties.sv ***
// Purpose: Protocol checks on the pins between transceiver end and link end.
// Assumes: One clock domain; NRST synchronous, active low.
// Notes:   Instantiated beside the interface, no bind.
module ulpi_port_properties
  import ulpi_port_pkg::*;
(
  input wire logic  CLOCK,
  input wire logic  NRST,
  input wire logic  dev_data_oe,
  input wire logic  lnk_data_oe,
  input wire logic  dir,
  input wire logic  dir_oe,
  input wire logic  nxt,
  input wire logic  nxt_oe,
  input wire logic  stp,
  input wire logic  chip_reset_n_pin,
  input wire logic  interface_clock_output
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  a_reset_pins_float: assert property (
    !chip_reset_n_pin && !$past(chip_reset_n_pin, 3) |-> !(dev_data_oe || dir_oe || nxt_oe))
    else $error("device drives a pin while held in reset");
  a_dir_driven_active: assert property (
    chip_reset_n_pin && $past(chip_reset_n_pin, 4) |-> dir_oe && nxt_oe)
    else $error("device not driving dir or nxt while active");
  a_data_needs_dir: assert property (dev_data_oe |-> dir)
    else $error("device drives data without dir high");
  a_idle_releases_bus: assert property (dir_oe && !dir |-> !dev_data_oe)
    else $error("device drives data with dir low");
  a_no_bus_clash: assert property (!(dev_data_oe && lnk_data_oe))
    else $error("both ends drive data");
  a_stop_one_cycle: assert property (stp |=> !stp)
    else $error("stop pulse longer than one cycle");
  a_stop_after_accept: assert property (stp |-> $past(nxt) && !dir)
    else $error("stop without a preceding accept");
  a_accept_needs_byte: assert property (
    nxt && !dir && !$past(dir) |-> $past(lnk_data_oe))
    else $error("accept without a presented byte");
  a_clock_out_runs: assert property (
    chip_reset_n_pin && $past(chip_reset_n_pin, 4) |=> $changed(interface_clock_output))
    else $error("interface clock output stalled");

  c_stop_seen: cover property (stp);
  c_dir_rise: cover property ($rose(dir));
  c_link_accept: cover property (nxt && !dir);
endmodule // ulpi_port_properties

// *** dv/tb_ulpi_phy_link_port.sv ***
// Purpose: Both ends joined; link-to-device and device-to-link packets checked.
// Assumes: Inputs driven at the falling edge; outputs read there too.
// Notes:   Released data wire shows the inverse of its last level.
`include "ulpi_port_cfg.svh"
module tb_ulpi_phy_link_port
  import ulpi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic  CLOCK = 0, NRST = 0;
  byte_t tx_byte = 8'h00, send_byte = 8'h00;
  logic  tx_valid = 0, tx_last = 0, send_valid = 0, send_last = 0;
  logic  tx_taken, rx_strobe, rx_end, clock_in_mode, active;
  logic  send_taken, recv_valid, ready;
  byte_t rx_byte, recv_byte, last_q;
  byte_t rxq[$], wq[$], rcq[$];
  int    n_fail = 0, cmp_count = 0, cyc = 0, low_cnt = 0, end_cnt = 0;
  byte_t lb[4] = '{8'h80, 8'h01, 8'h5a, 8'hc3};  // Link bytes, MSB and LSB alone
  byte_t pb[3] = '{8'h81, 8'h42, 8'h24};         // Device bytes

  ulpi_port_if u_if ();
  // Wire resolution; released bus keeps changing
  assign u_if.data_i = u_if.dev_data_oe ? u_if.dev_data_o :
                       (u_if.lnk_data_oe ? u_if.lnk_data_o : ~last_q);
  assign u_if.clk_strap = 1'b0;

  always #4 CLOCK = ~CLOCK;

  ulpi_phy_port i_ulpi_phy_port (.CLOCK(CLOCK), .NRST(NRST), .PORT(u_if),
    .TX_BYTE(tx_byte), .TX_VALID(tx_valid), .TX_LAST(tx_last), .RX_READY(1'b1),
    .TX_TAKEN(tx_taken), .RX_BYTE(rx_byte), .RX_STROBE(rx_strobe), .RX_END(rx_end),
    .CLOCK_IN_MODE(clock_in_mode), .ACTIVE(active));
  ulpi_link_end i_ulpi_link_end (.CLOCK(CLOCK), .NRST(NRST), .PORT(u_if),
    .SEND_BYTE(send_byte), .SEND_VALID(send_valid), .SEND_LAST(send_last),
    .SEND_TAKEN(send_taken), .RECV_BYTE(recv_byte), .RECV_VALID(recv_valid),
    .READY(ready));
  ulpi_port_properties i_ulpi_port_properties (.CLOCK(CLOCK), .NRST(NRST),
    .dev_data_oe(u_if.dev_data_oe), .lnk_data_oe(u_if.lnk_data_oe), .dir(u_if.dir),
    .dir_oe(u_if.dir_oe), .nxt(u_if.nxt), .nxt_oe(u_if.nxt_oe), .stp(u_if.stp),
    .chip_reset_n_pin(u_if.chip_reset_n_pin),
    .interface_clock_output(u_if.interface_clock_output));

  // ----------------------------------------------------------------
  // Monitors and timeout
  // ----------------------------------------------------------------
  always @(posedge CLOCK) begin
    last_q <= u_if.data_i;
    if (NRST && !u_if.chip_reset_n_pin) low_cnt <= low_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  always @(negedge CLOCK) begin
    if (rx_strobe === 1'b1) rxq.push_back(rx_byte);
    if (rx_end === 1'b1) end_cnt++;
    if (u_if.nxt === 1'b1 && u_if.dir === 1'b0 && u_if.lnk_data_oe === 1'b1 &&
        u_if.stp === 1'b0)
      wq.push_back(u_if.data_i);
    if (recv_valid === 1'b1 && recv_byte !== 8'h00 &&
        (rcq.size() == 0 || rcq[$] !== recv_byte)) rcq.push_back(recv_byte);
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input byte_t seen, input byte_t exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic lsend(input byte_t b, input logic last);
    int n;
    n = 0;
    send_byte = b;
    send_valid = 1;
    send_last = last;
    do begin
      @(negedge CLOCK);
      n++;
    end while (send_taken !== 1'b1 && n < 50);
    check(send_taken, 1);
  endtask
  task automatic psend(input byte_t b, input logic last);
    int n;
    n = 0;
    tx_byte = b;
    tx_valid = 1;
    tx_last = last;
    do begin
      @(negedge CLOCK);
      n++;
    end while (tx_taken !== 1'b1 && n < 50);
    check(tx_taken, 1);
    check(u_if.dir, 1);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    n = 0;
    repeat (6) @(negedge CLOCK);
    NRST = 1;
    repeat (10) @(negedge CLOCK);
    check(u_if.dir_oe | u_if.dev_data_oe | u_if.nxt_oe, 0);
    check(active, 0);
    while (ready !== 1'b1 && n < 400) begin
      @(negedge CLOCK);
      n++;
    end
    repeat (5) @(negedge CLOCK);
    check(byte_t'(low_cnt >= `RST_MIN_CYC), 1);
    check(active, 1);
    check(clock_in_mode, 0);
    for (int i = 0; i < 4; i++) lsend(lb[i], i >= 2);
    send_valid = 0;
    repeat (10) @(negedge CLOCK);
    check(byte_t'(rxq.size()), 4);
    check(byte_t'(wq.size()), 4);
    for (int i = 0; i < 4; i++) begin
      check(rxq[i], lb[i]);
      check(wq[i], lb[i]);
    end
    check(byte_t'(end_cnt), 2);
    for (int i = 0; i < 3; i++) psend(pb[i], i == 2);
    tx_valid = 0;
    repeat (10) @(negedge CLOCK);
    check(byte_t'(rcq.size() >= 3), 1);
    for (int i = 0; i < 3; i++) check(rcq[rcq.size() - 3 + i], pb[i]);
    check(u_if.dir, 0);
    check(u_if.dev_data_oe, 0);
    complete_run();
  end
endmodule // tb_ulpi_phy_link_port
